// ===== inc/oss_pkg.sv
// Package: constants and types for the output switch serial control block
package oss_pkg;
    localparam int          OSS_NUM_OUT   = 8;
    localparam logic [7:0]  OSS_OUT_OFF   = 8'hFF;
    localparam logic [7:0]  OSS_SHIFT_CLR = 8'h00;
    localparam int          OSS_FIFO_W    = 8;
    localparam int          OSS_FIFO_D    = 32;
    localparam int          OSS_FIFO_AW   = 5;
    localparam int          OSS_CLK_MHZ   = 20;
    localparam int          OSS_SCLK_MIN_NS = 333;
    localparam int          OSS_SCLK_MIN_CYC =
        (OSS_SCLK_MIN_NS * OSS_CLK_MHZ) / 1000;
    typedef enum logic [2:0] {
        OSS_IDLE  = 3'b001,
        OSS_SHIFT = 3'b010,
        OSS_LATCH = 3'b100
    } oss_state_e;
endpackage : oss_pkg

// ===== inc/oss_stream_if.sv
// Interface: valid/ready word stream between the link core and the FIFO
interface oss_stream_if;
    logic [7:0] data;
    logic       valid;
    logic       ready;
    modport src (output data, output valid, input ready);
    modport dst (input data, input valid, output ready);
endinterface : oss_stream_if

// ===== core/oss_fifo.sv
// Synchronous FIFO holding latched command words
module oss_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32,
    parameter int AW    = 5
) (
    input  wire logic             core_clk_i,
    input  wire logic             rst_b_i,
    input  wire logic             clk_en_i,
    oss_stream_if.dst             wr,
    output logic [WIDTH-1:0]      rd_data_o,
    output logic                  rd_valid_o,
    input  wire logic             rd_ready_i
);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0]      wp_ff, rp_ff, nxt_wp, nxt_rp;
    logic             full, empty, do_wr, do_rd;

    always_comb begin
        full    = (wp_ff[AW] != rp_ff[AW])
                  && (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
        empty   = (wp_ff == rp_ff);
        do_wr   = wr.valid && !full;
        do_rd   = rd_ready_i && !empty;
        nxt_wp  = do_wr ? wp_ff + (AW+1)'(1) : wp_ff;
        nxt_rp  = do_rd ? rp_ff + (AW+1)'(1) : rp_ff;
    end

    assign wr.ready   = !full;
    assign rd_valid_o = !empty;
    assign rd_data_o  = mem_ff[rp_ff[AW-1:0]];

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            wp_ff <= '0;
            rp_ff <= '0;
        end else if (clk_en_i) begin
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (clk_en_i && do_wr) begin
            mem_ff[wp_ff[AW-1:0]] <= wr.data;
        end
    end

    chk_fifo_no_over : assert property (@(posedge core_clk_i)
        disable iff (!rst_b_i) full |=> wp_ff == $past(wp_ff))
        else $error("fifo written while full");
endmodule : oss_fifo

// ===== core/oss_link.sv
// Serial control link of an eight-channel low-side output switch
module oss_link
    import oss_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        clk_en_i,
    input  wire logic        clr_b_i,
    input  wire logic        cs_b_i,
    input  wire logic        sclk_i,
    input  wire logic        sdi_i,
    input  wire logic [7:0]  drain_i,
    output logic [7:0]       gate_off_o,
    output logic             sdo_o,
    output logic             sdo_oe_o,
    output logic [7:0]       cmd_word_o,
    output logic             cmd_valid_o,
    input  wire logic        cmd_ready_i
);
    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    logic [4:0] s1_ff, s2_ff, s3_ff;
    logic [7:0] d1_ff, d2_ff;
    logic       cs_b, sclk, sdi, clr_b, cs_b_d, sclk_d;
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            s1_ff <= 5'h1B;
            s2_ff <= 5'h1B;
            s3_ff <= 5'h1B;
            d1_ff <= 8'hFF;
            d2_ff <= 8'hFF;
        end else if (clk_en_i) begin
            s1_ff <= {clr_b_i, cs_b_i, sclk_i, sdi_i, 1'b1};
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            d1_ff <= drain_i;
            d2_ff <= d1_ff;
        end
    end
    assign clr_b  = s2_ff[4];
    assign cs_b   = s2_ff[3];
    assign sclk   = s2_ff[2];
    assign sdi    = s2_ff[1];
    assign cs_b_d = s3_ff[3];
    assign sclk_d = s3_ff[2];

    logic cs_fall, cs_rise, sck_fall, sck_rise;
    assign cs_fall  = cs_b_d && !cs_b;
    assign cs_rise  = !cs_b_d && cs_b;
    // Clock edges are ignored while deselected
    // Each shift clock phase needs only one core cycle to be seen
    assign sck_fall = sclk_d && !sclk && !cs_b && !cs_b_d;
    assign sck_rise = !sclk_d && sclk && !cs_b && !cs_b_d;

    // ==========================================================
    // Shift engine
    // ==========================================================
    oss_state_e st_ff, nxt_st;
    logic [7:0] sh_ff, nxt_sh, lat_ff, nxt_lat;
    logic       so_ff, nxt_so, oe_ff, nxt_oe, push_ff, nxt_push;
    logic [7:0] wd_ff, nxt_wd;
    logic       fifo_rdy;

    always_comb begin
        nxt_st   = st_ff;
        nxt_sh   = sh_ff;
        nxt_lat  = lat_ff;
        nxt_so   = so_ff;
        nxt_oe   = oe_ff;
        nxt_push = push_ff && !fifo_rdy;
        nxt_wd   = wd_ff;
        case (st_ff)
            OSS_IDLE: begin
                if (cs_fall) begin
                    nxt_sh = d2_ff;
                    nxt_so = d2_ff[7];
                    nxt_oe = 1'b1;
                    nxt_st = OSS_SHIFT;
                end
            end
            OSS_SHIFT: begin
                if (sck_fall) begin
                    nxt_sh = {sh_ff[6:0], sdi};
                end
                if (sck_rise) begin
                    nxt_so = sh_ff[7];
                end
                if (cs_rise) begin
                    nxt_oe = 1'b0;
                    nxt_st = OSS_LATCH;
                end
            end
            OSS_LATCH: begin
                nxt_lat  = sh_ff;
                nxt_wd   = sh_ff;
                nxt_push = 1'b1;
                nxt_st   = OSS_IDLE;
            end
            default: nxt_st = OSS_IDLE;
        endcase
        if (!clr_b) begin
            nxt_sh  = OSS_SHIFT_CLR;
            nxt_lat = OSS_OUT_OFF;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            st_ff   <= OSS_IDLE;
            sh_ff   <= OSS_SHIFT_CLR;
            lat_ff  <= OSS_OUT_OFF;
            so_ff   <= 1'b0;
            oe_ff   <= 1'b0;
            push_ff <= 1'b0;
            wd_ff   <= 8'h00;
        end else if (clk_en_i) begin
            st_ff   <= nxt_st;
            sh_ff   <= nxt_sh;
            lat_ff  <= nxt_lat;
            so_ff   <= nxt_so;
            oe_ff   <= nxt_oe;
            push_ff <= nxt_push;
            wd_ff   <= nxt_wd;
        end
    end

    assign gate_off_o = lat_ff;
    assign sdo_o      = so_ff;
    assign sdo_oe_o   = oe_ff;

    // ==========================================================
    // Latched command log
    // ==========================================================
    // A full log holds the pending record in wd_ff until it has room, and a later latch overwrites it; the outputs still update
    oss_stream_if cmd_if ();
    assign cmd_if.data  = wd_ff;
    assign cmd_if.valid = push_ff;
    assign fifo_rdy     = cmd_if.ready;

    logic [7:0] fq_data;
    logic       fq_valid;
    oss_fifo #(
        .WIDTH (OSS_FIFO_W),
        .DEPTH (OSS_FIFO_D),
        .AW    (OSS_FIFO_AW)
    ) u_fifo (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .clk_en_i   (clk_en_i),
        .wr         (cmd_if),
        .rd_data_o  (fq_data),
        .rd_valid_o (fq_valid),
        .rd_ready_i (cmd_ready_i && (!cmd_valid_o))
    );

    logic [7:0] ow_ff, nxt_ow;
    logic       ov_ff, nxt_ov;
    always_comb begin
        nxt_ow = ow_ff;
        nxt_ov = ov_ff && !cmd_ready_i;
        if (!cmd_valid_o && fq_valid && cmd_ready_i) begin
            nxt_ow = fq_data;
            nxt_ov = 1'b1;
        end
    end
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            ow_ff <= 8'h00;
            ov_ff <= 1'b0;
        end else if (clk_en_i) begin
            ow_ff <= nxt_ow;
            ov_ff <= nxt_ov;
        end
    end
    assign cmd_word_o  = ow_ff;
    assign cmd_valid_o = ov_ff;

    // ==========================================================
    // Checks
    // ==========================================================
    chk_oe_on_select : assert property (@(posedge core_clk_i)
        disable iff (!rst_b_i) clk_en_i && cs_fall && st_ff == OSS_IDLE
        |=> sdo_oe_o)
        else $error("driver not enabled after select");
    chk_oe_off_idle : assert property (@(posedge core_clk_i)
        disable iff (!rst_b_i) st_ff == OSS_IDLE && !cs_fall |=> !sdo_oe_o
        || $past(st_ff) != OSS_IDLE)
        else $error("driver on while deselected");
    chk_latch_copy : assert property (@(posedge core_clk_i)
        disable iff (!rst_b_i) clk_en_i && st_ff == OSS_LATCH && clr_b
        |=> gate_off_o == $past(sh_ff))
        else $error("latch not loaded");
    chk_status_load : assert property (@(posedge core_clk_i)
        disable iff (!rst_b_i) clk_en_i && st_ff == OSS_IDLE && cs_fall
        && clr_b |=> sh_ff == $past(d2_ff) && sdo_o == sh_ff[7])
        else $error("status not loaded");
    chk_shift_in : assert property (@(posedge core_clk_i)
        disable iff (!rst_b_i) clk_en_i && st_ff == OSS_SHIFT && sck_fall
        && clr_b |=> sh_ff[0] == $past(sdi))
        else $error("bit not shifted in");
    chk_clear_off : assert property (@(posedge core_clk_i)
        disable iff (!rst_b_i) clk_en_i && !clr_b
        |=> gate_off_o == OSS_OUT_OFF && sh_ff == OSS_SHIFT_CLR)
        else $error("clear did not turn outputs off");
    chk_hold_desel : assert property (@(posedge core_clk_i)
        disable iff (!rst_b_i) clk_en_i && st_ff == OSS_IDLE && !cs_fall
        && clr_b |=> $stable(sh_ff))
        else $error("shift while deselected");
    chk_latch_stable : assert property (@(posedge core_clk_i)
        disable iff (!rst_b_i) st_ff != OSS_LATCH && clr_b
        |=> $stable(gate_off_o))
        else $error("outputs changed outside latch");

    cov_frame : cover property (@(posedge core_clk_i)
        st_ff == OSS_SHIFT ##1 st_ff == OSS_LATCH);
    cov_clear : cover property (@(posedge core_clk_i) !clr_b);
    cov_log_out : cover property (@(posedge core_clk_i)
        cmd_valid_o && cmd_ready_i);
endmodule : oss_link

// ===== tb/oss_host_model.sv
// Host-side serial master model for the output switch link
module oss_host_model (
    input  wire logic core_clk_i,
    input  wire logic sdo_i,
    input  wire logic sdo_oe_i,
    output logic      cs_b_o,
    output logic      sclk_o,
    output logic      sdi_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic last_q = 1'b0;
    logic miso;

    // Released line shows the inverse of its last driven level
    always @(posedge core_clk_i) begin
        if (sdo_oe_i) last_q <= sdo_i;
    end
    assign miso = sdo_oe_i ? sdo_i : ~last_q;

    initial begin
        cs_b_o = 1'b1;
        sclk_o = 1'b0;
        sdi_o  = 1'b0;
    end

    // ==========================================================
    // One frame of nbits, read back on each falling shift edge
    task automatic xfer(input logic [15:0] tx, input int nbits,
                        output logic [15:0] rx, output logic oe_ok);
        rx    = '0;
        oe_ok = 1'b1;
        @(posedge core_clk_i);
        sdi_o  <= tx[nbits-1];
        cs_b_o <= 1'b0;
        repeat (8) @(posedge core_clk_i);
        for (int i = nbits - 1; i >= 0; i--) begin
            sclk_o <= 1'b1;
            repeat (4) @(posedge core_clk_i);
            sclk_o <= 1'b0;
            #1;
            rx[i] = miso;
            oe_ok = oe_ok & sdo_oe_i;
            repeat (2) @(posedge core_clk_i);
            if (i > 0) sdi_o <= tx[i-1];
            repeat (2) @(posedge core_clk_i);
        end
        cs_b_o <= 1'b1;
        repeat (8) @(posedge core_clk_i);
    endtask

    // Clock and data wiggle while deselected; ends with clock low
    task automatic noise();
        for (int i = 0; i < 8; i++) begin
            repeat (4) @(posedge core_clk_i);
            sclk_o <= ~sclk_o;
            sdi_o  <= ~sdi_o;
        end
        repeat (4) @(posedge core_clk_i);
    endtask
endmodule // oss_host_model

// ===== tb/tb.sv
// Self-checking bench for the output switch link and its log FIFO
`define CHK(what, exp, got) \
    begin check_count++; if ((got) !== (exp)) begin n_fail++; \
    $display("MISMATCH %s exp %h got %h", what, exp, got); end end

module tb
    import oss_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic core_clk, rst_b, clk_en, clr_b, cs_b, sclk, sdi, sdo, sdo_oe;
    logic [7:0] drain, gate_off, cmd_word;
    logic cmd_valid, cmd_ready;
    int   n_fail = 0;
    int   check_count = 0;

    oss_link uut (.core_clk_i(core_clk), .rst_b_i(rst_b), .clk_en_i(clk_en),
        .clr_b_i(clr_b), .cs_b_i(cs_b), .sclk_i(sclk), .sdi_i(sdi),
        .drain_i(drain), .gate_off_o(gate_off), .sdo_o(sdo),
        .sdo_oe_o(sdo_oe), .cmd_word_o(cmd_word),
        .cmd_valid_o(cmd_valid), .cmd_ready_i(cmd_ready));
    oss_host_model host (.core_clk_i(core_clk), .sdo_i(sdo),
        .sdo_oe_i(sdo_oe), .cs_b_o(cs_b), .sclk_o(sclk), .sdi_o(sdi));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // ==========================================================
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic t_frames();
        logic [7:0]  tx [4] = '{8'hFF, 8'h00, 8'hA5, 8'h3C};
        logic [15:0] rx;
        logic        ok;
        for (int k = 0; k < 4; k++) begin
            drain <= 8'h96 ^ tx[k];
            host.xfer({8'h00, tx[k]}, 8, rx, ok);
            `CHK("status", 8'h96 ^ tx[k], rx[7:0]);
            `CHK("oe on", 1'b1, ok);
            `CHK("gate", tx[k], gate_off);
            `CHK("oe off", 1'b0, sdo_oe);
        end
    endtask

    task automatic t_idle_chain_clear();
        logic [15:0] rx;
        logic        ok;
        host.noise();
        `CHK("gate idle", 8'h3C, gate_off);
        drain <= 8'h69;
        host.xfer(16'hC35A, 16, rx, ok);
        `CHK("chain out", 16'h69C3, rx);
        `CHK("chain gate", 8'h5A, gate_off);
        clr_b <= 1'b0;
        repeat (4) @(posedge core_clk);
        `CHK("clear", OSS_OUT_OFF, gate_off);
        clr_b <= 1'b1;
        repeat (4) @(posedge core_clk);
    endtask

    // A full frame sent while the clock enable is low must leave no trace
    task automatic t_freeze();
        logic [15:0] rx;
        logic        ok;
        clk_en <= 1'b0;
        host.xfer(16'h0000, 8, rx, ok);
        `CHK("freeze gate", OSS_OUT_OFF, gate_off);
        `CHK("freeze oe", 1'b0, ok);
        clk_en <= 1'b1;
        repeat (4) @(posedge core_clk);
    endtask

    // Fill the log past its depth with the reader stalled, then drain
    task automatic t_fifo();
        logic [15:0] rx;
        logic        ok;
        int          pops = 0;
        cmd_ready <= 1'b0;
        repeat (4) @(posedge core_clk);
        for (int k = 0; k <= OSS_FIFO_D; k++) host.xfer(16'(k), 8, rx, ok);
        `CHK("log held", 1'b0, cmd_valid);
        `CHK("log gate", 8'(OSS_FIFO_D), gate_off);
        cmd_ready <= 1'b1;
        // Sampled mid-cycle, where the log outputs have settled
        for (int c = 0; c < 200 && pops <= OSS_FIFO_D; c++) begin
            @(negedge core_clk);
            if (cmd_valid === 1'b1) begin
                `CHK("log word", pops[7:0], cmd_word);
                pops++;
            end
        end
        `CHK("log count", OSS_FIFO_D + 1, pops);
    endtask

    initial begin
        rst_b = 1'b0;
        clk_en = 1'b1;
        clr_b = 1'b1;
        drain = OSS_OUT_OFF;
        cmd_ready = 1'b1;
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge core_clk);
        `CHK("reset gate", OSS_OUT_OFF, gate_off);
        `CHK("reset oe", 1'b0, sdo_oe);
        `CHK("reset log", 1'b0, cmd_valid);
        t_frames();
        t_idle_chain_clear();
        t_freeze();
        t_fifo();
        finish_test();
    end

    // Hang guard
    initial begin
        repeat (100000) @(posedge core_clk);
        n_fail++;
        finish_test();
    end
endmodule // tb
